//--- logic/csdm_map.svh
// register offsets, field positions, reset values and timing counts of the mode block
`ifndef CSDM_MAP_SVH
`define CSDM_MAP_SVH
// register byte offsets
`define CSDM_OFS_MODE 8'h00
`define CSDM_OFS_CTRL 8'h04
`define CSDM_OFS_TGT_VEL 8'h08
`define CSDM_OFS_TGT_TRQ 8'h0C
`define CSDM_OFS_MAX_TRQ 8'h10
`define CSDM_OFS_INTERP 8'h14
`define CSDM_OFS_STEP_NUM 8'h18
`define CSDM_OFS_STEP_DEN 8'h1C
`define CSDM_OFS_FE_WIN 8'h20
`define CSDM_OFS_FE_TMO 8'h24
`define CSDM_OFS_QS_DEC 8'h28
`define CSDM_OFS_QS_OPT 8'h2C
`define CSDM_OFS_STATUS 8'h30
`define CSDM_OFS_POS 8'h34
`define CSDM_OFS_POLES 8'h38
// field positions
`define CSDM_CTRL_CLOSED_LOOP 0
`define CSDM_CTRL_QUICK_STOP 1
`define CSDM_ST_SYNC 8
`define CSDM_ST_LIMIT 11
`define CSDM_ST_FOLLOW 12
`define CSDM_ST_FOLLOW_ERR 13
// mode selector codes
`define CSDM_MODE_CSV 8'h09
`define CSDM_MODE_CST 8'h0A
`define CSDM_MODE_STEP 8'hFF
// reset values
`define CSDM_RST_STEP_NUM 16'h0080
`define CSDM_RST_STEP_DEN 16'h0001
`define CSDM_RST_IP_PERIOD 8'h01
`define CSDM_RST_IP_INDEX 8'hFD
`define CSDM_RST_POLES 8'h32
// supported interpolation time index (-3)
`define CSDM_IP_INDEX_MS 8'hFD
// units per full step and full steps per pole pair
`define CSDM_FULL_STEP 16'h0200
`define CSDM_STEPS_PER_POLE 4
// timing: clock period and cycle time base, both in ns
`define CSDM_CLK_NS 25
`define CSDM_MS_NS 1000000
`define CSDM_MS_CYCLES (`CSDM_MS_NS / `CSDM_CLK_NS)
`endif

//--- logic/csdm_pkg.sv
// types of the cyclic setpoint and step/direction mode block
`default_nettype none
package csdm_pkg;
  // operating mode decoded from the selector byte
  typedef enum logic [1:0] {
    CSDM_M_IDLE = 2'b00,
    CSDM_M_CSV = 2'b01,
    CSDM_M_CST = 2'b10,
    CSDM_M_STEP = 2'b11
  } csdm_mode_e;
  // step scale divider state
  typedef enum logic [0:0] {
    CSDM_DIV_IDLE = 1'b0,
    CSDM_DIV_RUN = 1'b1
  } csdm_div_e;
  // complete state of the block
  typedef struct packed {
    logic [7:0] mode_sel;
    logic closed_loop;
    logic quick_stop;
    logic [31:0] tgt_vel;
    logic [15:0] tgt_trq;
    logic [15:0] max_trq;
    logic [7:0] ip_period;
    logic [7:0] ip_index;
    logic [15:0] step_num;
    logic [15:0] step_den;
    logic [31:0] fe_window;
    logic [15:0] fe_timeout;
    logic [31:0] qs_decel;
    logic [15:0] qs_option;
    logic [7:0] poles;
    logic [15:0] ms_cnt;
    logic [7:0] cyc_cnt;
    logic got_sp;
    logic sync;
    logic [31:0] vel_cmd;
    logic [15:0] trq_cmd;
    logic [31:0] pos;
    logic [15:0] frac;
    logic [15:0] quo;
    logic [15:0] rem;
    csdm_div_e div_state;
    logic [4:0] div_cnt;
    logic [15:0] div_q;
    logic [15:0] div_r;
    logic [15:0] fe_cnt;
    logic fe_flag;
    logic [2:0] s_clk;
    logic [2:0] s_dir;
    logic [2:0] s_lneg;
    logic [2:0] s_lpos;
    logic clk_lvl;
    logic dir_lvl;
    logic lim_neg;
    logic lim_pos;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } csdm_state_s;
endpackage
`default_nettype wire

//--- logic/csdm_top.sv
// cyclic velocity/torque and step/direction mode logic with an apb register file
`default_nettype none
`include "csdm_map.svh"
module csdm_top #(
  parameter int P_MS_CYCLES = `CSDM_MS_CYCLES
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // pulse/direction and limit switch pins
  input wire logic i_step_clk,
  input wire logic i_step_dir,
  input wire logic i_limit_neg,
  input wire logic i_limit_pos,
  // measured position from the control loop
  input wire logic [31:0] i_actual_pos,
  // commands to the control loop
  output logic [31:0] o_vel_cmd,
  output logic [15:0] o_trq_cmd,
  output logic [31:0] o_step_pos,
  output logic o_sync
);
  import csdm_pkg::*;

  localparam logic [15:0] MS_LAST = 16'(P_MS_CYCLES - 1);

  csdm_state_s st_reg; // registered state
  csdm_state_s st_next; // next state
  csdm_mode_e mode; // decoded selector
  logic setup; // apb setup phase
  logic wr; // write takes effect this edge
  logic ms_tick; // one-cycle pulse each millisecond
  logic win_end; // last tick of a cycle period
  logic ip_ok; // supported time index
  logic follow; // setpoint in use
  logic clk_rise; // filtered step clock rising edge
  logic [31:0] err; // demand minus actual
  logic [31:0] err_abs; // magnitude of error
  logic [16:0] div_trial; // divider shifted remainder
  logic [16:0] frac_sum; // fraction accumulation
  logic [31:0] step_amt; // scaled distance of this pulse
  logic [31:0] qs_next; // ramped velocity
  logic [31:0] rd; // read mux
  logic rd_ok; // address mapped
  logic [15:0] den_eff; // denominator, zero read as one

  // decode the signed selector byte into a mode
  // -1 and FFh are the same byte, so one code covers both spellings
  // any other value selects idle, which holds the velocity and torque commands at zero and leaves the step position held
  // a selector change takes effect on the edge after the write lands
  always_comb
  begin
    unique case (st_reg.mode_sel)
      `CSDM_MODE_CSV: mode = CSDM_M_CSV;
      `CSDM_MODE_CST: mode = CSDM_M_CST;
      `CSDM_MODE_STEP: mode = CSDM_M_STEP;
      default: mode = CSDM_M_IDLE;
    endcase
  end

  // read data multiplexer
  // unmapped offsets clear rd_ok, which turns into pslverr one cycle later
  // narrow fields sit in the low bits and the unused upper bits read zero, except the sign-extended mode byte and the full-steps high half of the poles word
  always_comb
  begin
    rd = 32'h0000_0000;
    rd_ok = 1'b1;
    unique case (i_paddr)
      // signed byte sign-extended on read
      `CSDM_OFS_MODE: rd = {{24{st_reg.mode_sel[7]}}, st_reg.mode_sel};
      `CSDM_OFS_CTRL: rd = {30'h0, st_reg.quick_stop, st_reg.closed_loop};
      `CSDM_OFS_TGT_VEL: rd = st_reg.tgt_vel;
      `CSDM_OFS_TGT_TRQ: rd = {16'h0000, st_reg.tgt_trq};
      `CSDM_OFS_MAX_TRQ: rd = {16'h0000, st_reg.max_trq};
      `CSDM_OFS_INTERP: rd = {16'h0000, st_reg.ip_index, st_reg.ip_period};
      `CSDM_OFS_STEP_NUM: rd = {16'h0000, st_reg.step_num};
      `CSDM_OFS_STEP_DEN: rd = {16'h0000, st_reg.step_den};
      `CSDM_OFS_FE_WIN: rd = st_reg.fe_window;
      `CSDM_OFS_FE_TMO: rd = {16'h0000, st_reg.fe_timeout};
      `CSDM_OFS_QS_DEC: rd = st_reg.qs_decel;
      `CSDM_OFS_QS_OPT: rd = {16'h0000, st_reg.qs_option};
      `CSDM_OFS_STATUS:
      begin
        // sync only has meaning in the cyclic modes
        // the follow bit reads zero outside the velocity and torque modes
        rd[`CSDM_ST_SYNC] = st_reg.sync && (mode == CSDM_M_CSV || mode == CSDM_M_CST);
        rd[`CSDM_ST_LIMIT] = st_reg.lim_neg | st_reg.lim_pos;
        rd[`CSDM_ST_FOLLOW] = follow;
        rd[`CSDM_ST_FOLLOW_ERR] = st_reg.fe_flag;
      end
      `CSDM_OFS_POS: rd = st_reg.pos;
      // low half: pole pairs, high half: full steps per revolution
      `CSDM_OFS_POLES: rd = {16'(st_reg.poles * `CSDM_STEPS_PER_POLE), 8'h00, st_reg.poles};
      default: rd_ok = 1'b0;
    endcase
  end

  // helper terms shared by the next-state logic
  // the step edge is taken from the filtered level, never the raw pin, so a
  // glitch shorter than one clock period cannot move the position
  always_comb
  begin
    setup = i_psel && !i_penable;
    wr = i_psel && i_penable && st_reg.pready && i_pwrite && !st_reg.pslverr;
    ms_tick = (st_reg.ms_cnt == MS_LAST);
    ip_ok = (st_reg.ip_index == `CSDM_IP_INDEX_MS);
    // period counted in milliseconds, zero treated as one
    win_end = ms_tick && (({1'b0, st_reg.cyc_cnt} + 9'h001) >= {1'b0, st_reg.ip_period});
    // follow drops at once when sync, time index or quick-stop fail
    follow = st_reg.sync && ip_ok && !st_reg.quick_stop &&
      (mode == CSDM_M_CSV || (mode == CSDM_M_CST && st_reg.closed_loop));
    clk_rise = (st_reg.s_clk[2] == st_reg.s_clk[1]) && st_reg.s_clk[1] && !st_reg.clk_lvl;
    err = st_reg.pos - i_actual_pos;
    err_abs = err[31] ? (32'h0000_0000 - err) : err;
    den_eff = (st_reg.step_den == 16'h0000) ? 16'h0001 : st_reg.step_den;
    div_trial = {st_reg.div_r, st_reg.div_q[15]};
    frac_sum = {1'b0, st_reg.frac} + {1'b0, st_reg.rem};
    step_amt = {16'h0000, st_reg.quo} + ((frac_sum >= {1'b0, den_eff}) ? 32'h1 : 32'h0);
    // ramp toward zero by the quick-stop deceleration per millisecond
    if (st_reg.vel_cmd[31])
      qs_next = ($signed(st_reg.vel_cmd) + $signed(st_reg.qs_decel) > 0) ? 32'h0 :
        st_reg.vel_cmd + st_reg.qs_decel;
    else
      qs_next = (st_reg.vel_cmd > st_reg.qs_decel) ? st_reg.vel_cmd - st_reg.qs_decel : 32'h0;
  end

  // next state of the whole block
  // every field starts from its registered value, so a branch that does not
  // touch a field leaves it held
  always_comb
  begin
    st_next = st_reg;
    // apb: answer in the first access cycle, zero wait states
    st_next.pready = setup;
    st_next.pslverr = setup && !rd_ok;
    // read data stands only with pready; zero at every other cycle so a stale
    // word cannot be mistaken for a fresh answer
    if (setup && rd_ok && !i_pwrite)
      st_next.prdata = rd;
    else
      st_next.prdata = 32'h0000_0000;
    // register writes; control bits gate the cyclic modes (closed loop for torque, quick-stop for velocity and torque)
    if (wr)
    begin
      unique case (i_paddr)
        `CSDM_OFS_MODE: st_next.mode_sel = i_pwdata[7:0];
        `CSDM_OFS_CTRL:
        begin
          st_next.closed_loop = i_pwdata[`CSDM_CTRL_CLOSED_LOOP];
          st_next.quick_stop = i_pwdata[`CSDM_CTRL_QUICK_STOP];
        end
        `CSDM_OFS_TGT_VEL: st_next.tgt_vel = i_pwdata;
        `CSDM_OFS_TGT_TRQ: st_next.tgt_trq = i_pwdata[15:0];
        `CSDM_OFS_MAX_TRQ: st_next.max_trq = i_pwdata[15:0];
        `CSDM_OFS_INTERP:
        begin
          st_next.ip_period = i_pwdata[7:0];
          st_next.ip_index = i_pwdata[15:8];
        end
        `CSDM_OFS_STEP_NUM: st_next.step_num = i_pwdata[15:0];
        `CSDM_OFS_STEP_DEN: st_next.step_den = i_pwdata[15:0];
        `CSDM_OFS_FE_WIN: st_next.fe_window = i_pwdata;
        `CSDM_OFS_FE_TMO: st_next.fe_timeout = i_pwdata[15:0];
        `CSDM_OFS_QS_DEC: st_next.qs_decel = i_pwdata;
        `CSDM_OFS_QS_OPT: st_next.qs_option = i_pwdata[15:0];
        `CSDM_OFS_POS: st_next.pos = i_pwdata;
        `CSDM_OFS_POLES: st_next.poles = i_pwdata[7:0];
        default: st_next.mode_sel = st_reg.mode_sel; // read-only status
      endcase
    end
    // millisecond time base
    // the same tick paces cycle windows, quick-stop braking and error timeout
    st_next.ms_cnt = ms_tick ? 16'h0000 : st_reg.ms_cnt + 16'h0001;
    // cycle window: a setpoint seen in each window keeps sync
    // a wrong time index forces sync low, which also stops both commands
    if (win_end)
    begin
      // a setpoint written on the closing edge still counts
      st_next.sync = ip_ok && (st_reg.got_sp ||
        (wr && (i_paddr == `CSDM_OFS_TGT_VEL || i_paddr == `CSDM_OFS_TGT_TRQ)));
      st_next.got_sp = 1'b0;
      st_next.cyc_cnt = 8'h00;
    end
    else
    begin
      if (wr && (i_paddr == `CSDM_OFS_TGT_VEL || i_paddr == `CSDM_OFS_TGT_TRQ))
        st_next.got_sp = 1'b1;
      if (ms_tick)
        st_next.cyc_cnt = st_reg.cyc_cnt + 8'h01;
    end
    // pin synchronisers: level accepted once stages two and three agree
    // the first stage may go metastable and is read by nothing but stage two
    st_next.s_clk = {st_reg.s_clk[1:0], i_step_clk};
    st_next.s_dir = {st_reg.s_dir[1:0], i_step_dir};
    st_next.s_lneg = {st_reg.s_lneg[1:0], i_limit_neg};
    st_next.s_lpos = {st_reg.s_lpos[1:0], i_limit_pos};
    if (st_reg.s_clk[2] == st_reg.s_clk[1])
      st_next.clk_lvl = st_reg.s_clk[1];
    if (st_reg.s_dir[2] == st_reg.s_dir[1])
      st_next.dir_lvl = st_reg.s_dir[1];
    if (st_reg.s_lneg[2] == st_reg.s_lneg[1])
      st_next.lim_neg = st_reg.s_lneg[1];
    if (st_reg.s_lpos[2] == st_reg.s_lpos[1])
      st_next.lim_pos = st_reg.s_lpos[1];
    // velocity command: direct copy, no ramp
    // quick-stop has priority over the setpoint; braking steps once per tick
    // and never overshoots through zero
    if (mode == CSDM_M_CSV && st_reg.quick_stop)
    begin
      // option zero stops at once, others brake with the deceleration
      // braking works on the magnitude, so the sign of the command is kept
      if (st_reg.qs_option == 16'h0000)
        st_next.vel_cmd = 32'h0000_0000;
      else if (ms_tick)
        st_next.vel_cmd = qs_next;
    end
    else if (mode == CSDM_M_CSV && follow)
    begin
      st_next.vel_cmd = st_reg.tgt_vel;
      // no motion into a tripped limit switch
      if ((st_reg.tgt_vel[31] && st_reg.lim_neg) ||
        (!st_reg.tgt_vel[31] && st_reg.lim_pos))
        st_next.vel_cmd = 32'h0000_0000;
    end
    else
      st_next.vel_cmd = 32'h0000_0000;
    // torque command: clamped to the maximum permissible torque
    // the setpoint is read relative to the configured maximum, so anything
    // beyond it in either direction is cut to the maximum
    if (mode == CSDM_M_CST && follow)
    begin
      if ($signed(st_reg.tgt_trq) > $signed(st_reg.max_trq))
        st_next.trq_cmd = st_reg.max_trq;
      else if ($signed(st_reg.tgt_trq) < -$signed(st_reg.max_trq))
        st_next.trq_cmd = 16'h0000 - st_reg.max_trq;
      else
        st_next.trq_cmd = st_reg.tgt_trq;
      if ((st_reg.tgt_trq[15] && st_reg.lim_neg) || (!st_reg.tgt_trq[15] && st_reg.lim_pos))
        st_next.trq_cmd = 16'h0000;
    end
    else
      st_next.trq_cmd = 16'h0000;
    // restart the scale division whenever numerator or denominator change
    // pulses that arrive during the sixteen cycles of the division are dropped;
    // the controller must not write the scale while it is stepping
    // the remainder carries into frac, so fractional steps are not lost
    if (wr && (i_paddr == `CSDM_OFS_STEP_NUM || i_paddr == `CSDM_OFS_STEP_DEN))
    begin
      st_next.div_state = CSDM_DIV_RUN;
      st_next.div_cnt = 5'h00;
      st_next.div_q = (i_paddr == `CSDM_OFS_STEP_NUM) ? i_pwdata[15:0] : st_reg.step_num;
      st_next.div_r = 16'h0000;
      st_next.frac = 16'h0000;
    end
    else
    begin
      unique case (st_reg.div_state)
        CSDM_DIV_IDLE:
        begin
          // one scaled step per filtered rising clock edge
          if (mode == CSDM_M_STEP && clk_rise &&
            !(st_reg.dir_lvl ? st_reg.lim_pos : st_reg.lim_neg))
          begin
            st_next.pos = st_reg.dir_lvl ? st_reg.pos + step_amt : st_reg.pos - step_amt;
            st_next.frac = (frac_sum >= {1'b0, den_eff}) ?
              16'(frac_sum - {1'b0, den_eff}) : frac_sum[15:0];
          end
        end
        CSDM_DIV_RUN:
        begin
          // restoring division, one quotient bit per clock
          // sixteen passes; the last one also latches quotient and remainder
          if (div_trial >= {1'b0, den_eff})
          begin
            st_next.div_r = 16'(div_trial - {1'b0, den_eff});
            st_next.div_q = {st_reg.div_q[14:0], 1'b1};
          end
          else
          begin
            st_next.div_r = div_trial[15:0];
            st_next.div_q = {st_reg.div_q[14:0], 1'b0};
          end
          st_next.div_cnt = st_reg.div_cnt + 5'h01;
          if (st_reg.div_cnt == 5'h0F)
          begin
            st_next.div_state = CSDM_DIV_IDLE;
            st_next.quo = (div_trial >= {1'b0, den_eff}) ? {st_reg.div_q[14:0], 1'b1} :
              {st_reg.div_q[14:0], 1'b0};
            st_next.rem = (div_trial >= {1'b0, den_eff}) ?
              16'(div_trial - {1'b0, den_eff}) : div_trial[15:0];
          end
        end
      endcase
    end
    // following error: only in stepping mode under closed loop
    // the counter saturates so a long excursion cannot wrap and clear the flag
    // returning into the corridor resets both counter and flag at once
    if (mode == CSDM_M_STEP && st_reg.closed_loop && (err_abs > st_reg.fe_window))
    begin
      if (ms_tick && st_reg.fe_cnt != 16'hFFFF)
        st_next.fe_cnt = st_reg.fe_cnt + 16'h0001;
      if (st_reg.fe_cnt > st_reg.fe_timeout)
        st_next.fe_flag = 1'b1;
    end
    else
    begin
      st_next.fe_cnt = 16'h0000;
      st_next.fe_flag = 1'b0;
    end
  end

  // state register
  // reset loads the default scale of a quarter step per pulse; quo starts
  // at the default numerator so stepping works before any division has run
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_reg <= '0;
      st_reg.step_num <= `CSDM_RST_STEP_NUM;
      st_reg.step_den <= `CSDM_RST_STEP_DEN;
      st_reg.quo <= `CSDM_RST_STEP_NUM;
      st_reg.ip_period <= `CSDM_RST_IP_PERIOD;
      st_reg.ip_index <= `CSDM_RST_IP_INDEX;
      st_reg.poles <= `CSDM_RST_POLES;
      st_reg.div_state <= CSDM_DIV_IDLE;
    end
    else
      st_reg <= st_next;
  end

  // outputs straight from the state register
  // no output passes through logic after the register
  assign o_prdata = st_reg.prdata;
  assign o_pready = st_reg.pready;
  assign o_pslverr = st_reg.pslverr;
  assign o_vel_cmd = st_reg.vel_cmd;
  assign o_trq_cmd = st_reg.trq_cmd;
  assign o_step_pos = st_reg.pos;
  assign o_sync = st_reg.sync;
endmodule
`default_nettype wire

//--- test/csdm_pulse_src.sv
// pulse/direction source standing in for the higher-level positioning controller
`default_nettype none
module csdm_pulse_src (
  // step pins toward the block
  output var logic o_step_clk,
  output var logic o_step_dir
);
  timeunit 1ns;
  timeprecision 1ps;
  // step clock idles low between bursts, direction starts positive
  initial o_step_clk = 1'b0;
  initial o_step_dir = 1'b1;
  // sends n pulses; a direction change first waits out the settle time
  task automatic send(input int n, input logic d);
    #7;
    if (d !== o_step_dir)
    begin
      o_step_dir = d;
      #35000;
    end
    repeat (n)
    begin
      o_step_clk = 1'b1;
      #200;
      o_step_clk = 1'b0;
      #800;
    end
  endtask
endmodule
`default_nettype wire

//--- test/csdm_top_checker.sv
// concurrent checks on the ports of the mode block
`default_nettype none
module csdm_top_checker #(
  parameter int P_MS_CYCLES = 40
) (
  // clock, reset and bus
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // step pin and results
  input wire logic i_step_clk,
  input wire logic [31:0] o_step_pos,
  input wire logic o_sync
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  logic step_q_reg;  // pin sampled once for edge detection
  logic [3:0] since_reg;  // cycles since the last pin rise, saturating
  // age of the last raw step rise
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      step_q_reg <= 1'b0;
      since_reg <= 4'hF;
    end
    else
    begin
      step_q_reg <= i_step_clk;
      if (i_step_clk && !step_q_reg)
        since_reg <= 4'h0;
      else if (since_reg != 4'hF)
        since_reg <= since_reg + 4'h1;
    end
  end
  ready_after_setup_a: assert property (i_psel && !i_penable |=> o_pready)
    else $error("no ready after setup");
  ready_single_a: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  ready_cause_a: assert property (o_pready |-> $past(i_psel && !i_penable))
    else $error("ready without setup");
  err_with_ready_a: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");
  rdata_idle_a: assert property (!o_pready |-> o_prdata == 32'h0)
    else $error("read data outside access");
  err_data_zero_a: assert property (o_pslverr |-> o_prdata == 32'h0)
    else $error("data on refused access");
  pos_change_cause_a: assert property ($changed(o_step_pos) |->
    since_reg <= 4'hA || $past(o_pready && i_pwrite && i_paddr == 8'h34))
    else $error("step position moved without pulse");
  sync_hold_a: assert property ($changed(o_sync) |=> $stable(o_sync)[*8])
    else $error("sync changed inside a window");
  cover property ($rose(o_sync));
  cover property (o_pslverr);
  cover property ($changed(o_step_pos));
endmodule
bind csdm_top csdm_top_checker #(.P_MS_CYCLES(P_MS_CYCLES)) CHK (.i_clock(i_clock),
  .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_step_clk(i_step_clk), .o_step_pos(o_step_pos), .o_sync(o_sync));
`default_nettype wire

//--- test/csdm_top_tb.sv
// self-checking bench of the cyclic and step/direction mode block
`default_nettype none
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin $display("CHECK FAILED %s exp %0h got %0h", nm, e, s); err_total++; end end
module csdm_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // one bus access with its expected answer
  typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] x; logic e;} csdm_row_s;
  csdm_row_s rows[11] = '{'{8'h18, 1'b0, 32'h0, 32'h80, 1'b0}, '{8'h1C, 1'b0, 32'h0, 32'h1, 1'b0},
    '{8'h14, 1'b0, 32'h0, 32'hFD01, 1'b0}, '{8'h38, 1'b0, 32'h0, 32'hC80032, 1'b0},
    '{8'h00, 1'b1, 32'hFF, 32'h0, 1'b0}, '{8'h00, 1'b0, 32'h0, 32'hFFFFFFFF, 1'b0},
    '{8'h00, 1'b1, 32'h9, 32'h0, 1'b0}, '{8'h00, 1'b0, 32'h0, 32'h9, 1'b0},
    '{8'h38, 1'b1, 32'h3, 32'h0, 1'b0}, '{8'h38, 1'b0, 32'h0, 32'hC0003, 1'b0},
    '{8'h3C, 1'b0, 32'h0, 32'h0, 1'b1}};
  int err_total = 0;
  int compares = 0;
  int wait_n = 0;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic lim_neg = 1'b0;
  logic lim_pos = 1'b0;
  logic [31:0] act_pos = 32'h0;
  logic [31:0] prdata, vel, spos, r;
  logic [15:0] trq;
  logic pready, pslverr, sync, sclk, sdir, e;
  // 40 MHz clock
  always #12.5 clk = ~clk;
  csdm_pulse_src SRC (.o_step_clk(sclk), .o_step_dir(sdir));
  csdm_top #(.P_MS_CYCLES(40)) DUT (.i_clock(clk), .i_rst_n(rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_step_clk(sclk),
    .i_step_dir(sdir), .i_limit_neg(lim_neg), .i_limit_pos(lim_pos),
    .i_actual_pos(act_pos), .o_vel_cmd(vel), .o_trq_cmd(trq), .o_step_pos(spos),
    .o_sync(sync));
  // counts and verdict
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // one apb transfer, entered and left just after a rising edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] rd_v, output logic er);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd_v = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    if (n >= 20)
    begin
      err_total++;
      report_and_stop();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d, r, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // at least one setpoint per window, as the far controller must
  task automatic feed(input logic [7:0] a, input logic [31:0] d, input int n);
    repeat (n)
    begin
      wr(a, d);
      cyc(25);
    end
  endtask
  // main sequence
  initial
  begin
    cyc(20);
    rst_n <= 1'b1;
    @(posedge clk);
    `CHK("pos after reset", 32'h0, spos)
    foreach (rows[i])
    begin
      apb(rows[i].a, rows[i].w, rows[i].d, r, e);
      `CHK("reg err", rows[i].e, e)
      if (!rows[i].w) `CHK("reg data", rows[i].x, r)
    end
    $display("test registers done");
    wr(8'h04, 32'h1);
    feed(8'h08, 32'h1234, 6);
    `CHK("sync", 1'b1, sync)
    `CHK("vel", 32'h1234, vel)
    apb(8'h30, 1'b0, 32'h0, r, e);
    `CHK("follow", 2'b11, {r[12], r[8]})
    wr(8'h2C, 32'h1);
    wr(8'h28, 32'h1000);
    wr(8'h04, 32'h3);
    wait_n = 0;
    while (vel === 32'h1234 && wait_n < 50)
    begin
      @(posedge clk);
      wait_n++;
    end
    if (wait_n >= 50)
    begin
      err_total++;
      report_and_stop();
    end
    `CHK("quick stop ramp", 32'h234, vel)
    wr(8'h2C, 32'h0);
    cyc(3);
    `CHK("quick stop", 32'h0, vel)
    wr(8'h04, 32'h0);
    cyc(100);
    `CHK("sync lost", 1'b0, sync)
    apb(8'h30, 1'b0, 32'h0, r, e);
    `CHK("follow lost", 1'b0, r[12])
    wr(8'h14, 32'h0001);
    feed(8'h08, 32'h55, 4);
    `CHK("bad index", 1'b0, sync)
    wr(8'h14, 32'hFD01);
    $display("test velocity done");
    wr(8'h00, 32'hA);
    wr(8'h10, 32'd100);
    feed(8'h0C, 32'd500, 3);
    `CHK("trq open loop", 16'h0, trq)
    apb(8'h30, 1'b0, 32'h0, r, e);
    `CHK("trq ignored", 1'b0, r[12])
    wr(8'h04, 32'h1);
    feed(8'h0C, 32'd500, 3);
    `CHK("trq clamp", 16'd100, trq)
    feed(8'h0C, 32'hFFE2, 3);
    `CHK("trq neg", 16'hFFE2, trq)
    apb(8'h30, 1'b0, 32'h0, r, e);
    `CHK("trq follow", 1'b1, r[12])
    $display("test torque done");
    wr(8'h04, 32'h0);
    wr(8'h00, 32'hFF);
    SRC.send(4, 1'b1);
    cyc(10);
    `CHK("quarter steps", 32'd512, spos)
    wr(8'h18, 32'd512);
    cyc(20);
    SRC.send(2, 1'b0);
    cyc(10);
    `CHK("full steps back", 32'hFFFFFE00, spos)
    lim_pos <= 1'b1;
    cyc(10);
    SRC.send(1, 1'b1);
    cyc(10);
    `CHK("limit blocks", 32'hFFFFFE00, spos)
    apb(8'h30, 1'b0, 32'h0, r, e);
    `CHK("limit flag", 1'b1, r[11])
    lim_pos <= 1'b0;
    $display("test step done");
    wr(8'h20, 32'd10);
    wr(8'h24, 32'd2);
    wr(8'h04, 32'h1);
    cyc(40);
    apb(8'h30, 1'b0, 32'h0, r, e);
    `CHK("fe early", 1'b0, r[13])
    cyc(200);
    apb(8'h30, 1'b0, 32'h0, r, e);
    `CHK("fe set", 1'b1, r[13])
    act_pos <= 32'hFFFFFE00;
    cyc(3);
    apb(8'h30, 1'b0, 32'h0, r, e);
    `CHK("fe clear", 1'b0, r[13])
    $display("test following error done");
    rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    @(posedge clk);
    `CHK("pos after mid reset", 32'h0, spos)
    apb(8'h18, 1'b0, 32'h0, r, e);
    `CHK("num after mid reset", 32'h80, r)
    $display("test mid-run reset done");
    report_and_stop();
  end
endmodule
`default_nettype wire
